//--- lcs_cascade_sync.sv
// Cascade position and backplane frame synchronisation
`timescale 1ns/100ps

// Behaviour
// R1: Up to sixteen drivers share one bus, told apart by select bit and subaddress.
// R2: Position equals select bit times eight plus the three subaddress pins.
// R3: After reset every device starts at the same frame phase without sync.
// R4: Sync pin is open drain: only pulls low, pull-up returns it high.
// R5: Sync is pulled low at the onset of the mode's last active backplane.
// R6: When not driving, watch sync and realign to another device's assertion.
// R7: After loss of alignment the first device asserting sync leads the cascade.
// R8: Exactly one device is clock master; the rest take the master's clock.
// R9: With an external clock all devices tie oscillator enable high.
// R10: Oscillator enable selects clock pin as oscillator output or clock input.
module lcs_cascade_sync #(
  parameter int unsigned OSC_HALF_CYC = lcs_pkg::OSC_HALF_CYC,
  parameter int unsigned SYNC_LOW_CYC = lcs_pkg::SYNC_LOW_CYC
) (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rstn,
  // Address straps
  input  wire logic                          slave_address_select_bit,
  input  wire logic                          subaddress_pin_0,
  input  wire logic                          subaddress_pin_1,
  input  wire logic                          subaddress_pin_2,
  // Configuration
  input  wire logic                          osc_enable,
  input  wire lcs_pkg::lcs_mode_t            drive_mode,
  // Display clock pin
  input  wire logic                          disp_clk_in,
  output logic                               disp_clk_out,
  output logic                               disp_clk_oe,
  // Sync pin, active low, open drain
  input  wire logic                          sync_n_in,
  output logic                               sync_n_out,
  output logic                               sync_n_oe,
  // Sequencer state
  output logic [lcs_pkg::POS_W-1:0]          cascade_position,
  output logic [lcs_pkg::PHASE_W-1:0]        backplane_phase,
  output logic                               frame_start,
  output logic                               realign_pulse
);

  lcs_clk_if clk_bus ();

  logic [lcs_pkg::POS_W-1:0]      pos_q;
  logic [lcs_pkg::PHASE_W-1:0]    phase_q;
  logic [lcs_pkg::PHASE_W-1:0]    phase_d;
  logic [lcs_pkg::PHASE_W-1:0]    last_phase;
  logic [lcs_pkg::SYNC_CNT_W-1:0] sync_cnt_q;
  logic                           sync_drv_q;
  logic                           sync_prev_q;
  logic                           frame_q;
  logic                           realign_q;
  logic                           foreign_fall;
  logic                           tick;
  logic [lcs_pkg::SYNC_CNT_W-1:0] low_len_q;

  // Display clock source
  lcs_clk_sel #(
    .HALF_CYC (OSC_HALF_CYC)
  ) u_clk_sel (
    .core_clk     (core_clk),
    .rstn         (rstn),
    .osc_enable   (osc_enable),
    .disp_clk_in  (disp_clk_in),
    .disp_clk_out (disp_clk_out),
    .disp_clk_oe  (disp_clk_oe),
    .clk_o        (clk_bus.src)
  );

  assign tick       = clk_bus.tick;
  assign last_phase = lcs_pkg::PHASE_W'(drive_mode);

  // Cascade position from straps
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pos_q <= '0;
    end else begin
      pos_q <= {slave_address_select_bit, subaddress_pin_2,
                subaddress_pin_1, subaddress_pin_0}; // R1 R2
    end
  end

  // Next backplane phase, wrapping at the mode's last phase
  always_comb begin
    if (phase_q >= last_phase) begin
      phase_d = lcs_pkg::PHASE_FIRST;
    end else begin
      phase_d = phase_q + lcs_pkg::PHASE_STEP;
    end
  end

  // Falling sync edge not caused by this device
  assign foreign_fall = sync_prev_q & ~sync_n_in & ~sync_drv_q; // R6

  // Phase sequencer; a foreign assertion overrides the local tick
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      phase_q <= lcs_pkg::PHASE_FIRST; // R3
    end else if (foreign_fall) begin
      phase_q <= last_phase; // R6
    end else if (tick) begin
      phase_q <= phase_d;
    end
  end

  // Frame start and realign markers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      frame_q   <= 1'b0;
      realign_q <= 1'b0;
    end else begin
      frame_q   <= tick & ~foreign_fall & (phase_d == lcs_pkg::PHASE_FIRST);
      realign_q <= foreign_fall;
    end
  end

  // Sync driver: least low time from onset of the last phase
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sync_drv_q <= 1'b0;
      sync_cnt_q <= '0;
    end else if (tick && !foreign_fall && phase_d == last_phase) begin
      sync_drv_q <= 1'b1; // R5 R7
      sync_cnt_q <= lcs_pkg::SYNC_CNT_W'(SYNC_LOW_CYC - 1);
    end else if (sync_cnt_q != '0) begin
      sync_cnt_q <= sync_cnt_q - 1'b1;
    end else begin
      sync_drv_q <= 1'b0;
    end
  end

  // Sync line monitor
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sync_prev_q <= 1'b1;
    end else begin
      sync_prev_q <= sync_n_in;
    end
  end

  // Open-drain pin: data is always low, enable carries the assertion
  assign sync_n_out       = 1'b0; // R4
  assign sync_n_oe        = sync_drv_q; // R4
  assign cascade_position = pos_q;
  assign backplane_phase  = phase_q;
  assign frame_start      = frame_q;
  assign realign_pulse    = realign_q;

  // Position follows the straps
  pos_map_a: assert property ( // R2
    @(posedge core_clk) disable iff (!rstn)
    ##1 (cascade_position == ($past(slave_address_select_bit) * lcs_pkg::CLUSTER_SIZE
         + {$past(subaddress_pin_2), $past(subaddress_pin_1), $past(subaddress_pin_0)}))
  ) else $error("cascade position does not follow straps");

  // Reset puts every device at the first phase, sync released
  reset_align_a: assert property ( // R3
    @(posedge core_clk)
    !rstn |=> (backplane_phase == lcs_pkg::PHASE_FIRST) && !sync_n_oe
  ) else $error("phase or sync not cleared by reset");

  // Pin never drives high
  sync_opendrain_a: assert property ( // R4
    @(posedge core_clk) disable iff (!rstn)
    sync_n_oe |-> (sync_n_out == 1'b0)
  ) else $error("sync pin driven high");

  // Sync asserted when the last phase begins
  sync_onset_a: assert property ( // R5
    @(posedge core_clk) disable iff (!rstn)
    (tick && !foreign_fall && phase_d == last_phase)
      |=> sync_n_oe && (backplane_phase == $past(last_phase))
  ) else $error("sync not asserted at last phase onset");

  // Assertion holds for at least eight cycles
  sync_width_a: assert property ( // R5
    @(posedge core_clk) disable iff (!rstn)
    $rose(sync_n_oe) |-> sync_n_oe [*8]
  ) else $error("sync low time too short");

  // Foreign assertion realigns the phase
  follow_a: assert property ( // R6
    @(posedge core_clk) disable iff (!rstn)
    (sync_prev_q && !sync_n_in && !sync_n_oe)
      |=> realign_pulse && (backplane_phase == $past(last_phase))
  ) else $error("no realignment to foreign sync");

  // Own assertion never realigns this device
  first_wins_a: assert property ( // R7
    @(posedge core_clk) disable iff (!rstn)
    sync_n_oe |=> !realign_pulse
  ) else $error("leader realigned to its own sync");

  // Clock pin direction follows the oscillator enable
  clk_dir_a: assert property ( // R10
    @(posedge core_clk) disable iff (!rstn)
    (disp_clk_oe == !osc_enable) && (clk_bus.ext_mode == osc_enable)
      && (!$past(osc_enable) || !disp_clk_out)
  ) else $error("clock pin direction wrong");

  // Length of the current own sync assertion, saturating
  always_ff @(posedge core_clk) begin
    if (!rstn || !sync_drv_q) begin
      low_len_q <= '0;
    end else if (low_len_q != '1) begin
      low_len_q <= low_len_q + 1'b1;
    end
  end

  // Own sync is released only after the least low time
  sync_low_len_a: assert property ( // R5
    @(posedge core_clk) disable iff (!rstn)
    $fell(sync_n_oe) |-> (low_len_q >= lcs_pkg::SYNC_CNT_W'(SYNC_LOW_CYC))
  ) else $error("sync released before least low time");

  // A step never leaves the phase beyond the mode's last phase
  phase_bound_a: assert property ( // R5
    @(posedge core_clk) disable iff (!rstn)
    (tick || foreign_fall) |=> (backplane_phase <= $past(last_phase))
  ) else $error("backplane phase beyond last phase");

endmodule : lcs_cascade_sync

//--- lcs_cascade_sync_tb.sv
// Self-checking bench for cascade position and frame sync
`timescale 1ns/100ps
module lcs_cascade_sync_tb;
  logic               core_clk = 1'b0;
  logic               rstn     = 1'b0;
  logic               sel      = 1'b0;
  logic               a2       = 1'b0;
  logic               a1       = 1'b0;
  logic               a0       = 1'b0;
  logic               osc_en   = 1'b1;
  lcs_pkg::lcs_mode_t mode_r   = lcs_pkg::LCS_MODE_MUX4;
  logic               ext_clk  = 1'b0;
  logic               peer_pull = 1'b0;
  logic               peer_oe;
  logic               clk_pin;
  logic               sync_n_line;
  logic               disp_clk_out;
  logic               disp_clk_oe;
  logic               sync_n_out;
  logic               sync_n_oe;
  logic [3:0]         cascade_position;
  logic [1:0]         backplane_phase;
  logic               frame_start;
  logic               realign_pulse;
  int                 failures = 0;
  int                 samples_checked = 0;

  always #12.5 core_clk = ~core_clk;

  // Pin resolution: pull-up on sync, clock pin driven by whoever enables it
  assign sync_n_line = !((sync_n_oe & !sync_n_out) | peer_oe);
  assign clk_pin     = disp_clk_oe ? disp_clk_out : ext_clk;

  lcs_cascade_sync #(.OSC_HALF_CYC(4), .SYNC_LOW_CYC(8)) uut (
    .core_clk(core_clk), .rstn(rstn), .slave_address_select_bit(sel),
    .subaddress_pin_0(a0), .subaddress_pin_1(a1), .subaddress_pin_2(a2),
    .osc_enable(osc_en), .drive_mode(mode_r), .disp_clk_in(clk_pin),
    .disp_clk_out(disp_clk_out), .disp_clk_oe(disp_clk_oe), .sync_n_in(sync_n_line),
    .sync_n_out(sync_n_out), .sync_n_oe(sync_n_oe), .cascade_position(cascade_position),
    .backplane_phase(backplane_phase), .frame_start(frame_start),
    .realign_pulse(realign_pulse));

  lcs_peer_model #(.HOLD_CYC(8)) peer (
    .core_clk(core_clk), .pull_req(peer_pull), .sync_n_oe(peer_oe));

  task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // One external clock period; counts own low cycles on the line and frame starts
  task automatic tick(output int hi, output int fs);
    hi = 0;
    fs = 0;
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk);
      ext_clk <= (i < 3);
      #1;
      if (sync_n_oe === 1'b1 && sync_n_line === 1'b0) hi++;
      if (frame_start === 1'b1) fs++;
    end
  endtask : tick

  task automatic t_position();
    for (int p = 0; p < 16; p++) begin
      @(posedge core_clk);
      {sel, a2, a1, a0} <= p[3:0];
      repeat (2) @(posedge core_clk);
      #1;
      chk("cascade_position", p[3:0], cascade_position);
    end
    $display("test position done");
  endtask : t_position

  task automatic t_osc();
    int   tg;
    logic prev;
    tg = 0;
    @(posedge core_clk);
    osc_en <= 1'b0;
    @(posedge core_clk);
    #1;
    prev = disp_clk_out;
    chk("disp_clk_oe", 4'h1, {3'h0, disp_clk_oe});
    repeat (40) begin
      @(posedge core_clk);
      #1;
      if (disp_clk_out !== prev) tg++;
      prev = disp_clk_out;
    end
    chk("osc toggles", 4'ha, tg[3:0]);
    @(posedge core_clk);
    osc_en <= 1'b1;
    @(posedge core_clk);
    #1;
    chk("disp_clk_oe", 4'h0, {3'h0, disp_clk_oe});
    $display("test oscillator done");
  endtask : t_osc

  task automatic t_modes();
    int hi;
    int fs;
    int n;
    int e;
    for (int m = 0; m < 4; m++) begin
      @(posedge core_clk);
      mode_r <= lcs_pkg::lcs_mode_t'(m);
      n = 0;
      do begin
        tick(hi, fs);
        n++;
      end while (backplane_phase !== 2'h0 && n < 6);
      for (int k = 1; k <= m + 1; k++) begin
        e = k % (m + 1);
        tick(hi, fs);
        chk("backplane_phase", e[3:0], {2'h0, backplane_phase});
        chk("sync low cycles", (e == m) ? 4'h8 : 4'h0, hi[3:0]);
        chk("frame_start", (e == 0) ? 4'h1 : 4'h0, fs[3:0]);
      end
    end
    $display("test drive modes done");
  endtask : t_modes

  task automatic t_realign();
    int pulses;
    int drove;
    int hi;
    int fs;
    pulses = 0;
    drove = 0;
    @(posedge core_clk);
    mode_r <= lcs_pkg::LCS_MODE_MUX3;
    peer_pull <= 1'b1;
    @(posedge core_clk);
    peer_pull <= 1'b0;
    repeat (12) begin
      @(posedge core_clk);
      #1;
      if (realign_pulse === 1'b1) pulses++;
      if (sync_n_oe !== 1'b0) drove++;
    end
    chk("realign_pulse", 4'h1, pulses[3:0]);
    chk("own sync drive", 4'h0, drove[3:0]);
    chk("backplane_phase", 4'h2, {2'h0, backplane_phase});
    tick(hi, fs);
    chk("backplane_phase", 4'h0, {2'h0, backplane_phase});
    chk("frame_start", 4'h1, fs[3:0]);
    $display("test realign done");
  endtask : t_realign

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  initial begin
    #(25 * 3000);
    failures++;
    $display("Error watchdog expected done seen hang");
    summarize();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    #1;
    chk("backplane_phase", 4'h0, {2'h0, backplane_phase});
    chk("sync_n_oe", 4'h0, {3'h0, sync_n_oe});
    chk("sync_n_out", 4'h0, {3'h0, sync_n_out});
    $display("test reset done");
    t_position();
    t_osc();
    t_modes();
    t_realign();
    summarize();
  end
endmodule : lcs_cascade_sync_tb

//--- lcs_clk_if.sv
// Display clock tick carried from the clock selector to the sequencer
`timescale 1ns/100ps
interface lcs_clk_if;
  logic tick;
  logic ext_mode;

  modport src (output tick, output ext_mode);
  modport dst (input tick, input ext_mode);
endinterface : lcs_clk_if

//--- lcs_clk_sel.sv
// Display clock source select: internal oscillator out, or clock pin in
`timescale 1ns/100ps
module lcs_clk_sel #(
  parameter int unsigned HALF_CYC = lcs_pkg::OSC_HALF_CYC
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // Oscillator enable strap
  input  wire logic osc_enable,
  // Display clock pin
  input  wire logic disp_clk_in,
  output logic      disp_clk_out,
  output logic      disp_clk_oe,
  // Tick toward the sequencer
  lcs_clk_if.src    clk_o
);

  logic [lcs_pkg::OSC_CNT_W-1:0] div_q;
  logic                          osc_q;
  logic                          pin_prev_q;
  logic                          tick_q;
  logic                          div_end;

  assign div_end = (div_q == lcs_pkg::OSC_CNT_W'(HALF_CYC - 1));

  // Internal oscillator divider, idle while the pin is an input
  always_ff @(posedge core_clk) begin
    if (!rstn || osc_enable) begin
      div_q <= '0;
      osc_q <= 1'b0;
    end else if (div_end) begin
      div_q <= '0;
      osc_q <= ~osc_q;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // Rising edge of the chosen display clock
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pin_prev_q <= disp_clk_in;
      tick_q     <= 1'b0;
    end else begin
      pin_prev_q <= disp_clk_in;
      if (osc_enable) begin
        tick_q <= disp_clk_in & ~pin_prev_q; // R10
      end else begin
        tick_q <= div_end & ~osc_q;
      end
    end
  end

  // Pin drives only with the oscillator running
  assign disp_clk_out   = osc_q;
  assign disp_clk_oe    = ~osc_enable; // R10
  assign clk_o.tick     = tick_q;
  assign clk_o.ext_mode = osc_enable;

endmodule : lcs_clk_sel

//--- lcs_peer_model.sv
// Neighbour cascade device that pulls the shared sync line low on command
`timescale 1ns/100ps
module lcs_peer_model #(
  parameter int unsigned HOLD_CYC = 8
) (
  // Clock
  input  wire logic core_clk,
  // Command and open-drain enable
  input  wire logic pull_req,
  output logic      sync_n_oe
);
  int unsigned cnt_q = 0;

  // Holds the line low for the least low time, then lets the pull-up win
  always_ff @(posedge core_clk) begin
    if (pull_req) begin
      cnt_q <= HOLD_CYC;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end

  assign sync_n_oe = (cnt_q != 0);
endmodule : lcs_peer_model

//--- lcs_pkg.sv
// Constants and types shared by the cascade sync block
package lcs_pkg;

  // Core clock rate
  localparam int unsigned CORE_HZ      = 40_000_000;
  localparam int unsigned CORE_MHZ     = 40;

  // Internal display oscillator, typical rate
  localparam int unsigned OSC_HZ       = 1536;
  localparam int unsigned OSC_HALF_CYC = CORE_HZ / (2 * OSC_HZ);
  localparam int unsigned OSC_CNT_W    = 16;

  // Least low time of the sync line, in ns, and in core cycles (rounded up)
  localparam int unsigned SYNC_LOW_NS  = 1000;
  localparam int unsigned SYNC_LOW_CYC = (SYNC_LOW_NS * CORE_MHZ + 999) / 1000;
  localparam int unsigned SYNC_CNT_W   = 6;

  // Cascade addressing
  localparam int unsigned CASCADE_MAX  = 16;
  localparam int unsigned POS_W        = 4;
  localparam int unsigned CLUSTER_SIZE = 8;

  // Backplane phase counter
  localparam int unsigned PHASE_W      = 2;
  localparam logic [1:0]  PHASE_FIRST  = 2'h0;
  localparam logic [1:0]  PHASE_STEP   = 2'h1;

  // Multiplex drive mode; the code is also the index of the last active phase
  typedef enum logic [1:0] {
    LCS_MODE_STATIC = 2'b00,
    LCS_MODE_MUX2   = 2'b01,
    LCS_MODE_MUX3   = 2'b10,
    LCS_MODE_MUX4   = 2'b11
  } lcs_mode_t;

endpackage : lcs_pkg
